// ==== core/pcv_pkg.sv ====
package pcv_pkg;
  // sizes
  localparam int NFUNC = 4;
  localparam int NCH = 4;
  localparam int NPEER = 3;
  localparam int CH_W = 2;
  localparam int VAL_W = 16;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CNT_W = 3;
  localparam int TMR_W = 8;
  localparam int BYP_ENT_W = 3;
  // functions 0..1 reactor trip, 2..3 safeguard initiation
  localparam int RT_LSB = 0;
  localparam int RT_N = 2;
  localparam int SG_LSB = 2;
  localparam int SG_N = 2;
  localparam logic [CNT_W-1:0] VOTE_MIN = 3'h2;
  // timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int COMP_FRAME_NS = 400;
  localparam int COMP_LIMIT_NS = 200;
  localparam int VOTE_FRAME_NS = 320;
  localparam int VOTE_LIMIT_NS = 160;
  localparam int COMP_FRAME_CYC = COMP_FRAME_NS / CLK_PERIOD_NS;
  localparam int COMP_LIMIT_CYC = COMP_LIMIT_NS / CLK_PERIOD_NS;
  localparam int VOTE_FRAME_CYC = VOTE_FRAME_NS / CLK_PERIOD_NS;
  localparam int VOTE_LIMIT_CYC = VOTE_LIMIT_NS / CLK_PERIOD_NS;
  localparam int EXEC_WORK_CYC = NFUNC;
  // register offsets
  localparam logic [ADDR_W-1:0] ADDR_SETPT0 = 8'h00;
  localparam logic [ADDR_W-1:0] SETPT_MASK = 8'h0C;
  localparam int SETPT_IDX_LSB = 2;
  localparam logic [ADDR_W-1:0] ADDR_CHBYP = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_OPBYP = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_OPCLR = 8'h18;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h1C;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h20;
  localparam logic [ADDR_W-1:0] ADDR_CMD = 8'h24;
  // field positions
  localparam int CHB_CH_LSB = 2;
  localparam int CHB_SET_BIT = 4;
  localparam int OPB_CLR_LSB = 4;
  localparam int CTRL_RSP_BIT = 0;
  localparam int CTRL_CSTALL_BIT = 1;
  localparam int CTRL_VSTALL_BIT = 2;
  localparam int CTRL_TEST_LSB = 4;
  localparam int ST_VOTE_LSB = 4;
  localparam int ST_COVR_BIT = 8;
  localparam int ST_VOVR_BIT = 9;
  localparam int ST_REJ_BIT = 10;
  localparam int ST_ACT_LSB = 12;
  localparam int CMD_RESET_BIT = 0;
  // reset values
  localparam logic [VAL_W-1:0] SETPT_RST = 16'hFFFF;
  localparam logic [VAL_W-1:0] OPCLR_RST = 16'hFFFF;
  localparam logic [VAL_W-1:0] PRETRIP_MARGIN = 16'h0100;
  localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;
  typedef enum logic [1:0] {
    PCV_IDLE = 2'b01,
    PCV_BUSY = 2'b10
  } pcv_exec_t;
endpackage

// ==== core/pcv_exec_timer.sv ====
`timescale 1ns/100ps
module pcv_exec_timer
  import pcv_pkg::*;
#(
  parameter int WORK_CYC = 4,
  parameter int LIMIT_CYC = 20
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // period start and test stall
  input wire logic start,
  input wire logic stall,
  // overrun pulse
  output logic overrun
);
  pcv_exec_t state;
  logic [TMR_W-1:0] workCnt;
  logic [TMR_W-1:0] watchCnt;
  logic done;
  logic limitHit;

  assign done = (state == PCV_BUSY) && !stall &&
    (workCnt == TMR_W'(WORK_CYC - 1));
  assign limitHit = (state == PCV_BUSY) &&
    (watchCnt == TMR_W'(LIMIT_CYC - 1));

  // processor work, finishes after a fixed count unless stalled
  always_ff @(posedge clk) begin
    if (!rst_n || start) begin
      workCnt <= '0;
    end else if (state == PCV_BUSY && !stall) begin
      workCnt <= workCnt + 1'b1;
    end
  end

  // independent supervision of the period
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= PCV_IDLE;
      watchCnt <= '0;
      overrun <= 1'b0;
    end else begin
      overrun <= 1'b0;
      case (state)
        PCV_IDLE: begin
          watchCnt <= '0;
          if (start) begin
            state <= PCV_BUSY;
          end
        end
        PCV_BUSY: begin
          watchCnt <= watchCnt + 1'b1;
          if (start || (limitHit && !done)) begin
            overrun <= 1'b1;
            watchCnt <= '0;
            state <= start ? PCV_BUSY : PCV_IDLE;
          end else if (done) begin
            state <= PCV_IDLE;
          end
        end
        default: state <= PCV_IDLE;
      endcase
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_overrun_limit: assert property (
    limitHit && !done && !start |=> overrun)
    else $error("execution overrun not flagged at limit");
  a_no_false_overrun: assert property (
    state == PCV_BUSY && done && !start |=> !overrun)
    else $error("overrun flagged on a period that finished");
endmodule

// ==== core/pcv_vote_slice.sv ====
`timescale 1ns/100ps
module pcv_vote_slice
  import pcv_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // evaluation enable
  input wire logic en,
  // like trips, slot 0 is own channel
  input wire logic [NCH-1:0] trips,
  // bypass state of this function
  input wire logic bypValid,
  input wire logic [CH_W-1:0] bypCh,
  input wire logic inhibit,
  // vote result
  output logic vote
);
  logic [NCH-1:0] eff;
  logic [CNT_W-1:0] effCnt;
  logic [CNT_W-1:0] rawCnt;

  // drop the bypassed channel, count the rest
  always_comb begin
    eff = trips;
    if (bypValid) begin
      eff[bypCh] = 1'b0;
    end
    effCnt = '0;
    rawCnt = '0;
    for (int i = 0; i < NCH; i++) begin
      effCnt = effCnt + CNT_W'(eff[i]);
      rawCnt = rawCnt + CNT_W'(trips[i]);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      vote <= 1'b0;
    end else if (en) begin
      vote <= (effCnt >= VOTE_MIN) && !inhibit;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_vote_two_of: assert property (
    en && effCnt < VOTE_MIN |=> !vote)
    else $error("vote raised with fewer than two trips");
  a_bypass_excl: assert property (
    en && bypValid && trips[bypCh] && rawCnt == VOTE_MIN |=> !vote)
    else $error("bypassed channel counted in vote");
endmodule

// ==== core/pcv_voter_top.sv ====
// The address-and-strobe port and the address map are this design's own decisions.
`timescale 1ns/100ps
// Functional notes
// - comparator trips when value exceeds setpoint
// - voter takes own plus three peer trips
// - output only with two or more trips
// - vote uses trip states and their bypasses
// - channel bypass makes it two of three
// - at most one channel bypass per function
// - operating bypass auto clears near protected region
// - reactor trip vote actuates own switchgear channel
// - real trip needs two switchgear channels
// - trip means coils de-energized
// - comparator and voter run fixed asynchronous periods
// - independent timer flags each period overrun
// - test function annunciates failure on overrun
// - test processor tests processors, evaluates bypasses
// - operator enters bypasses, setpoints, sees status
// - transfer select picks control room or panel
// - accept manual safeguard initiation requests
// - manual action runs to completion
// - manual initiation gives same outputs as automatic
module pcv_voter_top
  import pcv_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [DATA_W-1:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [DATA_W-1:0] regRdata,
  // digitized process values
  input wire logic [NFUNC-1:0][VAL_W-1:0] procValue,
  // like trips from the three peer channels
  input wire logic [NPEER-1:0][NFUNC-1:0] peerTrip,
  // manual initiation switches
  input wire logic [NFUNC-1:0] manualMcr,
  input wire logic [NFUNC-1:0] manualRsp,
  // actuation outputs
  output logic switchgearEnergized,
  output logic [SG_N-1:0] safeguardInit,
  // operator display
  output logic [NFUNC-1:0] tripStatus,
  output logic [NFUNC-1:0] pretripStatus,
  output logic [NFUNC-1:0] bypassStatus,
  output logic [NFUNC-1:0] opBypassStatus,
  // test function
  output logic failAnnunciate
);
  localparam int SYNC_W = NFUNC * VAL_W + NPEER * NFUNC + 2 * NFUNC;

  logic [SYNC_W-1:0] syncA;
  logic [SYNC_W-1:0] syncB;
  logic [NFUNC-1:0][VAL_W-1:0] procSync;
  logic [NPEER-1:0][NFUNC-1:0] peerSync;
  logic [NFUNC-1:0] mcrSync;
  logic [NFUNC-1:0] rspSync;

  logic [NFUNC-1:0][VAL_W-1:0] setpt;
  logic [VAL_W-1:0] opClr;
  logic rspSel;
  logic compStall;
  logic voteStall;
  logic [NFUNC-1:0] testForce;
  logic [NFUNC-1:0] bypValid;
  logic [NFUNC-1:0][CH_W-1:0] bypCh;
  logic [NFUNC-1:0] opByp;
  logic [NFUNC-1:0] ownTrip;
  logic [NFUNC-1:0] vote;
  logic [NFUNC-1:0] act;
  logic compOvr;
  logic voteOvr;
  logic bypReject;

  logic [TMR_W-1:0] compDiv;
  logic [TMR_W-1:0] voteDiv;
  logic compEn;
  logic voteEn;
  logic compOvrPulse;
  logic voteOvrPulse;

  logic wrSetpt;
  logic wrChByp;
  logic wrOpByp;
  logic wrStatus;
  logic resetCmd;
  logic [CH_W-1:0] reqFunc;
  logic [CH_W-1:0] reqCh;
  logic reqSet;
  logic rejectNow;
  logic [NFUNC-1:0] manualReq;
  logic [NFUNC-1:0] compareVec;
  logic [NFUNC-1:0] pretripVec;
  logic [NFUNC-1:0] opClrHit;
  logic [NFUNC-1:0] next_act;
  logic [NFUNC*BYP_ENT_W-1:0] bypRead;
  logic [DATA_W-1:0] next_rdata;

  // two-flop synchronisers for process values, peer trips and manual switches; the register port is not synchronised
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      syncA <= '0;
      syncB <= '0;
    end else begin
      syncA <= {procValue, peerTrip, manualMcr, manualRsp};
      syncB <= syncA;
    end
  end
  assign {procSync, peerSync, mcrSync, rspSync} = syncB;

  // fixed frame dividers, mutually unrelated periods
  always_ff @(posedge clk) begin
    if (!rst_n || compEn) begin
      compDiv <= '0;
    end else begin
      compDiv <= compDiv + 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n || voteEn) begin
      voteDiv <= '0;
    end else begin
      voteDiv <= voteDiv + 1'b1;
    end
  end
  assign compEn = compDiv == TMR_W'(COMP_FRAME_CYC - 1);
  assign voteEn = voteDiv == TMR_W'(VOTE_FRAME_CYC - 1);

  // write decode
  assign wrSetpt = regWr && ((regAddr & ~SETPT_MASK) == ADDR_SETPT0);
  assign wrChByp = regWr && regAddr == ADDR_CHBYP;
  assign wrOpByp = regWr && regAddr == ADDR_OPBYP;
  assign wrStatus = regWr && regAddr == ADDR_STATUS;
  assign resetCmd = regWr && regAddr == ADDR_CMD &&
    regWdata[CMD_RESET_BIT];
  assign reqFunc = regWdata[CH_W-1:0];
  assign reqCh = regWdata[CHB_CH_LSB +: CH_W];
  assign reqSet = regWdata[CHB_SET_BIT];
  assign rejectNow = wrChByp && reqSet && bypValid[reqFunc] &&
    bypCh[reqFunc] != reqCh;

  // operator entries: setpoints and permissive level
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      setpt <= {NFUNC{SETPT_RST}};
      opClr <= OPCLR_RST;
    end else begin
      if (wrSetpt) begin
        setpt[regAddr[SETPT_IDX_LSB +: CH_W]] <= regWdata[VAL_W-1:0];
      end
      if (regWr && regAddr == ADDR_OPCLR) begin
        opClr <= regWdata[VAL_W-1:0];
      end
    end
  end

  // control: station transfer and test injection
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rspSel <= 1'b0;
      compStall <= 1'b0;
      voteStall <= 1'b0;
      testForce <= '0;
    end else if (regWr && regAddr == ADDR_CTRL) begin
      rspSel <= regWdata[CTRL_RSP_BIT];
      compStall <= regWdata[CTRL_CSTALL_BIT];
      voteStall <= regWdata[CTRL_VSTALL_BIT];
      testForce <= regWdata[CTRL_TEST_LSB +: NFUNC];
    end
  end

  // channel bypass table, one entry per function
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bypValid <= '0;
      bypCh <= '0;
    end else if (wrChByp) begin
      if (reqSet && !bypValid[reqFunc]) begin
        bypValid[reqFunc] <= 1'b1;
        bypCh[reqFunc] <= reqCh;
      end else if (!reqSet && bypCh[reqFunc] == reqCh) begin
        bypValid[reqFunc] <= 1'b0;
      end
    end
  end

  // operating bypasses: operator sets, plant conditions clear
  always_comb begin
    for (int f = 0; f < NFUNC; f++) begin
      opClrHit[f] = procSync[f] >= opClr;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      opByp <= '0;
    end else begin
      for (int f = 0; f < NFUNC; f++) begin
        if (opClrHit[f]) begin
          opByp[f] <= 1'b0;
        end else if (wrOpByp && regWdata[f]) begin
          opByp[f] <= 1'b1;
        end else if (wrOpByp && regWdata[OPB_CLR_LSB + f]) begin
          opByp[f] <= 1'b0;
        end
      end
    end
  end

  // bistable comparators and pre-trip
  always_comb begin
    for (int f = 0; f < NFUNC; f++) begin
      compareVec[f] = (procSync[f] > setpt[f]) || testForce[f];
      pretripVec[f] = ({1'b0, procSync[f]} + {1'b0, PRETRIP_MARGIN}) >
        {1'b0, setpt[f]};
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ownTrip <= '0;
      pretripStatus <= '0;
    end else if (compEn) begin
      ownTrip <= compareVec;
      pretripStatus <= pretripVec;
    end
  end

  // one voter per function, own trip in slot 0
  for (genvar f = 0; f < NFUNC; f++) begin : g_vote
    pcv_vote_slice u_slice (
      .clk(clk),
      .rst_n(rst_n),
      .en(voteEn),
      .trips({peerSync[2][f], peerSync[1][f], peerSync[0][f],
        ownTrip[f]}),
      .bypValid(bypValid[f]),
      .bypCh(bypCh[f]),
      .inhibit(opByp[f]),
      .vote(vote[f])
    );
  end

  // execution supervision of both processors
  pcv_exec_timer #(
    .WORK_CYC(EXEC_WORK_CYC),
    .LIMIT_CYC(COMP_LIMIT_CYC)
  ) u_comp_tmr (
    .clk(clk),
    .rst_n(rst_n),
    .start(compEn),
    .stall(compStall),
    .overrun(compOvrPulse)
  );
  pcv_exec_timer #(
    .WORK_CYC(EXEC_WORK_CYC),
    .LIMIT_CYC(VOTE_LIMIT_CYC)
  ) u_vote_tmr (
    .clk(clk),
    .rst_n(rst_n),
    .start(voteEn),
    .stall(voteStall),
    .overrun(voteOvrPulse)
  );

  // sticky status, set wins over write-one-to-clear
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      compOvr <= 1'b0;
      voteOvr <= 1'b0;
      bypReject <= 1'b0;
    end else begin
      compOvr <= compOvrPulse ||
        (compOvr && !(wrStatus && regWdata[ST_COVR_BIT]));
      voteOvr <= voteOvrPulse ||
        (voteOvr && !(wrStatus && regWdata[ST_VOVR_BIT]));
      bypReject <= rejectNow ||
        (bypReject && !(wrStatus && regWdata[ST_REJ_BIT]));
    end
  end

  // manual and automatic share one latched actuation path
  always_comb begin
    manualReq = rspSel ? rspSync : mcrSync;
    for (int f = 0; f < NFUNC; f++) begin
      next_act[f] = vote[f] || manualReq[f] ||
        (act[f] && !resetCmd);
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      act <= '0;
    end else begin
      act <= next_act;
    end
  end

  // outputs, de-energize to trip
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      switchgearEnergized <= 1'b1;
      safeguardInit <= '0;
      tripStatus <= '0;
      bypassStatus <= '0;
      opBypassStatus <= '0;
      failAnnunciate <= 1'b0;
    end else begin
      // only this channel's breaker; a trip needs two
      switchgearEnergized <= !(|act[RT_LSB +: RT_N]);
      safeguardInit <= act[SG_LSB +: SG_N];
      tripStatus <= ownTrip;
      bypassStatus <= bypValid;
      opBypassStatus <= opByp;
      failAnnunciate <= compOvr || voteOvr;
    end
  end

  // register read
  always_comb begin
    for (int f = 0; f < NFUNC; f++) begin
      bypRead[f*BYP_ENT_W +: BYP_ENT_W] = {bypValid[f], bypCh[f]};
    end
    next_rdata = DATA_ZERO;
    if ((regAddr & ~SETPT_MASK) == ADDR_SETPT0) begin
      next_rdata[VAL_W-1:0] = setpt[regAddr[SETPT_IDX_LSB +: CH_W]];
    end else begin
      case (regAddr)
        ADDR_CHBYP: next_rdata[NFUNC*BYP_ENT_W-1:0] = bypRead;
        ADDR_OPBYP: next_rdata[NFUNC-1:0] = opByp;
        ADDR_OPCLR: next_rdata[VAL_W-1:0] = opClr;
        ADDR_CTRL: begin
          next_rdata[CTRL_RSP_BIT] = rspSel;
          next_rdata[CTRL_CSTALL_BIT] = compStall;
          next_rdata[CTRL_VSTALL_BIT] = voteStall;
          next_rdata[CTRL_TEST_LSB +: NFUNC] = testForce;
        end
        ADDR_STATUS: begin
          next_rdata[NFUNC-1:0] = ownTrip;
          next_rdata[ST_VOTE_LSB +: NFUNC] = vote;
          next_rdata[ST_COVR_BIT] = compOvr;
          next_rdata[ST_VOVR_BIT] = voteOvr;
          next_rdata[ST_REJ_BIT] = bypReject;
          next_rdata[ST_ACT_LSB +: NFUNC] = act;
        end
        default: next_rdata = DATA_ZERO;
      endcase
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      regRdata <= DATA_ZERO;
    end else begin
      regRdata <= regRd ? next_rdata : DATA_ZERO;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_comp_trip_value: assert property (
    compEn |=> ownTrip == $past(compareVec))
    else $error("comparator trip does not follow value and setpoint");
  a_single_bypass: assert property (
    rejectNow
      |=> bypValid == $past(bypValid) && bypCh == $past(bypCh))
    else $error("second channel bypass accepted");
  a_reject_flag: assert property (
    rejectNow |=> bypReject)
    else $error("rejected bypass request not flagged");
  a_opbyp_clear: assert property (
    opByp[3] && opClrHit[3] |=> !opByp[3])
    else $error("operating bypass kept past permissive");
  a_opbyp_manual: assert property (
    !opByp[1] && !(wrOpByp && regWdata[1]) |=> !opByp[1])
    else $error("operating bypass set without request");
  a_deenergize_trip: assert property (
    vote[0] |=> act[0] ##1 !switchgearEnergized)
    else $error("reactor trip vote did not open switchgear");
  a_manual_sealin: assert property (
    act[2] && !resetCmd |=> act[2] [*2] or resetCmd)
    else $error("manual action dropped before reset");
  a_manual_same: assert property (
    manualReq[3] |=> ##1 safeguardInit[1])
    else $error("manual initiation not on safeguard output");
  a_overrun_annunc: assert property (
    compOvrPulse |=> ##1 failAnnunciate)
    else $error("overrun not annunciated");
endmodule

// ==== sim/pcv_peer_model.sv ====
`timescale 1ns/100ps
module pcv_peer_model
  import pcv_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // bench requests
  input wire logic [NPEER-1:0][NFUNC-1:0] tripReq,
  input wire logic [NPEER-1:0] peerSwDown,
  // device side
  input wire logic switchgearEnergized,
  output logic [NPEER-1:0][NFUNC-1:0] peerTrip,
  output logic reactorTripped
);
  logic [2:0] downCnt;
  // each peer sends one like trip per function
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      peerTrip <= '0;
    end else begin
      peerTrip <= tripReq;
    end
  end
  // breakers open only with two switchgear channels down
  always_comb begin
    downCnt = 3'(!switchgearEnergized) + 3'(peerSwDown[0])
      + 3'(peerSwDown[1]) + 3'(peerSwDown[2]);
  end
  assign reactorTripped = downCnt >= 3'h2;
endmodule

// ==== sim/pcv_voter_top_tb.sv ====
`timescale 1ns/100ps
module pcv_voter_top_tb
  import pcv_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [ADDR_W-1:0] regAddr = '0;
  logic [DATA_W-1:0] regWdata = '0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [DATA_W-1:0] regRdata;
  logic [NFUNC-1:0][VAL_W-1:0] procValue = '0;
  logic [NPEER-1:0][NFUNC-1:0] tripReq = '0;
  logic [NPEER-1:0][NFUNC-1:0] peerTrip;
  logic [NPEER-1:0] peerSwDown = '0;
  logic [NFUNC-1:0] manualMcr = '0;
  logic [NFUNC-1:0] manualRsp = '0;
  logic switchgearEnergized;
  logic [SG_N-1:0] safeguardInit;
  logic [NFUNC-1:0] tripStatus;
  logic [NFUNC-1:0] pretripStatus;
  logic [NFUNC-1:0] bypassStatus;
  logic [NFUNC-1:0] opBypassStatus;
  logic failAnnunciate;
  logic reactorTripped;
  logic [DATA_W-1:0] rdv;
  int numErrors = 0;
  int samplesChecked = 0;

  always #4 clk = ~clk;

  pcv_voter_top i_pcv_voter_top (.clk(clk), .rst_n(rst_n),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .procValue(procValue),
    .peerTrip(peerTrip), .manualMcr(manualMcr), .manualRsp(manualRsp),
    .switchgearEnergized(switchgearEnergized),
    .safeguardInit(safeguardInit), .tripStatus(tripStatus),
    .pretripStatus(pretripStatus), .bypassStatus(bypassStatus),
    .opBypassStatus(opBypassStatus), .failAnnunciate(failAnnunciate));

  pcv_peer_model i_pcv_peer_model (.clk(clk), .rst_n(rst_n),
    .tripReq(tripReq), .peerSwDown(peerSwDown),
    .switchgearEnergized(switchgearEnergized), .peerTrip(peerTrip),
    .reactorTripped(reactorTripped));

  task automatic chk(input logic [DATA_W-1:0] seen,
                     input logic [DATA_W-1:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      numErrors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic pause(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    rdv = regRdata;
  endtask

  task automatic t_reset();
    chk(32'(switchgearEnergized), 32'h0000_0001);
    chk(32'(safeguardInit), 32'h0000_0000);
    rd(ADDR_SETPT0);
    chk(rdv, 32'h0000_FFFF);
    rd(8'h3C);
    chk(rdv, 32'h0000_0000);
  endtask

  task automatic t_compare();
    wr(ADDR_SETPT0, 32'h0000_1000);
    @(posedge clk);
    procValue[0] <= 16'h1000;
    pause(120);
    chk(32'(tripStatus[0]), 32'h0000_0000);
    chk(32'(pretripStatus[0]), 32'h0000_0001);
    @(posedge clk);
    procValue[0] <= 16'h1001;
    pause(120);
    chk(32'(tripStatus[0]), 32'h0000_0001);
    chk(32'(switchgearEnergized), 32'h0000_0001);
    @(posedge clk);
    procValue[0] <= 16'h0000;
    pause(120);
    chk(32'(tripStatus[0]), 32'h0000_0000);
    chk(32'(pretripStatus[0]), 32'h0000_0000);
  endtask

  task automatic t_vote();
    @(posedge clk);
    tripReq[0][0] <= 1'b1;
    pause(120);
    chk(32'(switchgearEnergized), 32'h0000_0001);
    @(posedge clk);
    tripReq[1][0] <= 1'b1;
    pause(120);
    chk(32'(switchgearEnergized), 32'h0000_0000);
    chk(32'(reactorTripped), 32'h0000_0000);
    @(posedge clk);
    peerSwDown[0] <= 1'b1;
    tripReq <= '0;
    pause(120);
    chk(32'(reactorTripped), 32'h0000_0001);
    chk(32'(switchgearEnergized), 32'h0000_0000);
    rd(ADDR_STATUS);
    chk(32'(rdv[ST_ACT_LSB]), 32'h0000_0001);
    wr(ADDR_CMD, 32'h0000_0001);
    peerSwDown <= '0;
    pause(10);
    chk(32'(switchgearEnergized), 32'h0000_0001);
  endtask

  task automatic t_bypass();
    wr(ADDR_CHBYP, 32'h0000_0016);
    @(posedge clk);
    tripReq[0][2] <= 1'b1;
    tripReq[1][2] <= 1'b1;
    pause(120);
    chk(32'(bypassStatus[2]), 32'h0000_0001);
    chk(32'(safeguardInit[0]), 32'h0000_0000);
    wr(ADDR_CHBYP, 32'h0000_001A);
    rd(ADDR_STATUS);
    chk(32'(rdv[ST_REJ_BIT]), 32'h0000_0001);
    rd(ADDR_CHBYP);
    chk(32'(rdv[8:6]), 32'h0000_0005);
    @(posedge clk);
    tripReq[2][2] <= 1'b1;
    pause(120);
    chk(32'(safeguardInit[0]), 32'h0000_0001);
    @(posedge clk);
    tripReq <= '0;
    wr(ADDR_CHBYP, 32'h0000_0006);
    wr(ADDR_STATUS, 32'h0000_0400);
    pause(120);
    wr(ADDR_CMD, 32'h0000_0001);
    pause(10);
    chk(32'(bypassStatus[2]), 32'h0000_0000);
    chk(32'(safeguardInit[0]), 32'h0000_0000);
  endtask

  task automatic t_opbyp();
    wr(ADDR_OPCLR, 32'h0000_8000);
    wr(ADDR_OPBYP, 32'h0000_0008);
    @(posedge clk);
    tripReq[0][3] <= 1'b1;
    tripReq[1][3] <= 1'b1;
    pause(120);
    chk(32'(opBypassStatus), 32'h0000_0008);
    chk(32'(safeguardInit[1]), 32'h0000_0000);
    @(posedge clk);
    procValue[3] <= 16'h8000;
    pause(120);
    chk(32'(opBypassStatus[3]), 32'h0000_0000);
    chk(32'(safeguardInit[1]), 32'h0000_0001);
    @(posedge clk);
    tripReq <= '0;
    procValue[3] <= 16'h0000;
    pause(120);
    wr(ADDR_CMD, 32'h0000_0001);
    pause(10);
    chk(32'(safeguardInit[1]), 32'h0000_0000);
  endtask

  task automatic t_manual();
    @(posedge clk);
    manualMcr <= 4'b0101;
    pause(8);
    chk(32'(switchgearEnergized), 32'h0000_0000);
    chk(32'(safeguardInit), 32'h0000_0001);
    @(posedge clk);
    manualMcr <= '0;
    pause(10);
    chk(32'(safeguardInit), 32'h0000_0001);
    wr(ADDR_CMD, 32'h0000_0001);
    pause(10);
    chk(32'(safeguardInit), 32'h0000_0000);
    chk(32'(switchgearEnergized), 32'h0000_0001);
    wr(ADDR_CTRL, 32'h0000_0001);
    @(posedge clk);
    manualMcr <= 4'b1000;
    pause(8);
    chk(32'(safeguardInit), 32'h0000_0000);
    @(posedge clk);
    manualRsp <= 4'b1000;
    pause(8);
    chk(32'(safeguardInit), 32'h0000_0002);
    @(posedge clk);
    manualMcr <= '0;
    manualRsp <= '0;
    pause(4);
    wr(ADDR_CMD, 32'h0000_0001);
    wr(ADDR_CTRL, 32'h0000_0000);
    pause(10);
    chk(32'(safeguardInit), 32'h0000_0000);
  endtask

  task automatic t_overrun();
    wr(ADDR_CTRL, 32'h0000_0002);
    pause(120);
    chk(32'(failAnnunciate), 32'h0000_0001);
    rd(ADDR_STATUS);
    chk(32'(rdv[ST_COVR_BIT]), 32'h0000_0001);
    wr(ADDR_CTRL, 32'h0000_0000);
    pause(60);
    wr(ADDR_STATUS, 32'h0000_0100);
    pause(4);
    chk(32'(failAnnunciate), 32'h0000_0000);
  endtask

  task automatic tallyAndFinish();
    $display("checks %0d errors %0d", samplesChecked, numErrors);
    if (numErrors == 0 && samplesChecked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    pause(1);
    t_reset();
    t_compare();
    t_vote();
    t_bypass();
    t_opbyp();
    t_manual();
    t_overrun();
    tallyAndFinish();
  end

  initial begin
    repeat (20000) @(posedge clk);
    numErrors++;
    tallyAndFinish();
  end
endmodule
